// >>> logic/analog_pdo_defines.svh
// Purpose: Offsets, reset values and coding constants of the analog PDO packer
// Assumes: 12-bit APB byte address, one 32-bit word per register
// Notes: Arrays of eight channels span 32 bytes each
`ifndef ANALOG_PDO_DEFINES_SVH
`define ANALOG_PDO_DEFINES_SVH
`define OFS_CTRL 12'h000
`define OFS_CHAN_EN 12'h004
`define OFS_MODE 12'h008
`define OFS_IRQ_STATUS 12'h00C
`define OFS_IRQ_MASK 12'h010
`define OFS_DELTA 12'h020
`define OFS_PV 12'h040
`define OFS_VGAIN 12'h060
`define OFS_VOFF 12'h080
`define OFS_IGAIN 12'h0A0
`define OFS_IOFF 12'h0C0
`define OFS_SFACT 12'h0E0
`define OFS_SOFF 12'h100
`define OFS_MAP 12'h140
`define CTRL_SEND_ALL 8
`define IRQ_TX 0
`define IRQ_RANGE 1
`define RST_GAIN 32'h0001_0000
`define RST_ZERO 32'h0000_0000
// 6.947e-4 and 7.825e-7, each scaled by 2^32
`define K_VOLT 32'h002D_8721
`define K_CURR 32'h0000_0D21
`define COB_TX1 11'h180
`define COB_TX2 11'h280
`define COB_TX3 11'h380
`define COB_TX4 11'h480
`define OBJ_VALUE 16'h7130
`define OBJ_STATE 16'h6150
`define SIZE_VALUE 8'h10
`define SIZE_STATE 8'h08
`define ST_OK 8'h00
`define ST_UNDER 8'h01
`define ST_OVER 8'h02
`define TX_LEN 4'h6
`endif

// >>> logic/analog_pdo_pkg.sv
// Purpose: Types shared by the analog PDO packer
// Assumes: Nothing beyond the defines header
// Notes: Types only
package analog_pdo_pkg;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01
  } tx_state_t;
endpackage

// >>> logic/calc_if.sv
// Purpose: Request and result of one channel conversion
// Assumes: Single clock domain
// Notes: Result follows a request by one clock
`timescale 1ns/1ps
interface calc_if;
  logic start;
  logic current_mode;
  logic [2:0] chan;
  logic signed [15:0] raw;
  logic signed [31:0] cal_gain;
  logic signed [31:0] cal_offset;
  logic signed [31:0] scale;
  logic signed [31:0] soffset;
  logic done;
  logic [2:0] done_chan;
  logic [15:0] pv;
  logic [7:0] state;
  modport ctrl (output start, current_mode, chan, raw, cal_gain, cal_offset, scale, soffset,
                input done, done_chan, pv, state);
  modport unit (input start, current_mode, chan, raw, cal_gain, cal_offset, scale, soffset,
                output done, done_chan, pv, state);
endinterface

// >>> logic/channel_calc.sv
// Purpose: Raw field value to saturated 16-bit process value
// Assumes: Gains and offsets in signed Q16.16
// Notes: One result per clock, latency one clock
`timescale 1ns/1ps
`include "analog_pdo_defines.svh"
module channel_calc
  import analog_pdo_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Conversion port
  calc_if.unit cu
);
  logic signed [63:0] kx, uncal, cal, fin, whole;
  logic [15:0] pv_reg, pv_next;
  logic [7:0] state_reg, state_next;
  logic done_reg;
  logic [2:0] chan_reg;

  always_comb begin
    kx = cu.current_mode ? {32'h0000_0000, `K_CURR} : {32'h0000_0000, `K_VOLT};
    uncal = (64'(cu.raw) * kx) >>> 16;
    cal = ((uncal * 64'(cu.cal_gain)) >>> 16) + 64'(cu.cal_offset);
    fin = ((cal * 64'(cu.scale)) >>> 16) + 64'(cu.soffset);
    whole = fin >>> 16;
    if (whole > 64'sd32767) begin
      pv_next = 16'h7FFF;
      state_next = `ST_OVER;
    end else if (whole < -64'sd32768) begin
      pv_next = 16'h8000;
      state_next = `ST_UNDER;
    end else begin
      pv_next = whole[15:0];
      state_next = `ST_OK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pv_reg <= 16'h0000;
      state_reg <= `ST_OK;
      done_reg <= 1'b0;
      chan_reg <= 3'h0;
    end else if (ce) begin
      pv_reg <= pv_next;
      state_reg <= state_next;
      done_reg <= cu.start;
      chan_reg <= cu.chan;
    end
  end

  assign cu.pv = pv_reg;
  assign cu.state = state_reg;
  assign cu.done = done_reg;
  assign cu.done_chan = chan_reg;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_calc_latency: assert property (ce && cu.start |=> cu.done)
    else $error("conversion result missing");
  chk_state_sat: assert property (cu.done && cu.state != `ST_OK |->
    cu.pv == ((cu.state == `ST_OVER) ? 16'h7FFF : 16'h8000))
    else $error("state byte and saturation disagree");
  chk_volt_unity: assert property (ce && cu.start && !cu.current_mode && cu.raw == 16'sh7FFF &&
    cu.cal_gain == `RST_GAIN && cu.cal_offset == 0 && cu.scale == `RST_GAIN && cu.soffset == 0
    |=> cu.pv == 16'h0016)
    else $error("voltage conversion factor wrong");
endmodule

// >>> logic/analog_pdo_packer.sv
// Purpose: Eight-channel analog value scaling and packing into four transmit objects
// Assumes: Samples arrive one channel per strobe; CAN controller drains tx_* by valid/ready
// Notes: All state freezes while ce is low, the APB slave included
// Summary of operation
// - Four transmit objects, identifiers 180h/280h/380h/480h plus node id, four entries each.
// - Object n carries channels 2n and 2n+1, in object order.
// - Bytes 0-1 and 2 first channel value/state; bytes 3-4 and 5 second channel.
// - Each mapping entry reads as object index, channel subindex, size in bits.
// - Apply mode calibration gain and offset, then user scale factor and offset.
// - Change of at least delta since last send retransmits; zero delta disables.
// - State byte: 0 no error, 1 range underflow, 2 range exceeded.
`timescale 1ns/1ps
`include "analog_pdo_defines.svh"
module analog_pdo_packer
  import analog_pdo_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Raw samples
  input wire logic sample_valid,
  input wire logic [2:0] sample_chan,
  input wire logic [15:0] raw_field_value,
  // External send requests, one bit per object
  input wire logic [3:0] tx_request,
  // Object stream to the CAN controller
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [10:0] tx_cob_id,
  output logic [3:0] tx_len,
  output logic [47:0] tx_data,
  // Interrupt
  output logic irq
);
  calc_if cu ();

  logic [6:0] node_reg, node_next;
  logic [7:0] en_reg, en_next, mode_reg, mode_next;
  logic [1:0] mask_reg, mask_next, status_reg, status_next, irq_set, irq_clr;
  logic [15:0] delta_reg [8], delta_next [8];
  logic [31:0] vgain_reg [8], vgain_next [8], voff_reg [8], voff_next [8];
  logic [31:0] igain_reg [8], igain_next [8], ioff_reg [8], ioff_next [8];
  logic [31:0] sfact_reg [8], sfact_next [8], soff_reg [8], soff_next [8];
  logic [15:0] pv_reg [8], pv_next [8], last_reg [8], last_next [8];
  logic [7:0] cst_reg [8], cst_next [8];
  logic [3:0] pending_reg, pending_next, set_pend, clr_pend;
  tx_state_t tx_state_reg, tx_state_next;
  logic [1:0] tx_pdo_reg, tx_pdo_next;
  logic [10:0] tx_cob_reg, tx_cob_next;
  logic [47:0] tx_data_reg, tx_data_next;
  logic [31:0] prdata_reg, prdata_next, rd_data;
  logic err_reg, err_next, rd_err, fresh_reg, fresh_next, wr_en;
  logic [2:0] idx;

  function automatic logic in_arr(input logic [11:0] a, input logic [11:0] base);
    return a[11:5] == base[11:5];
  endfunction

  function automatic logic [1:0] low_pdo(input logic [3:0] p);
    if (p[0]) return 2'd0;
    if (p[1]) return 2'd1;
    if (p[2]) return 2'd2;
    return 2'd3;
  endfunction

  function automatic logic [10:0] cob_id(input logic [1:0] pdo, input logic [6:0] node);
    logic [10:0] base;
    unique case (pdo)
      2'd0: base = `COB_TX1;
      2'd1: base = `COB_TX2;
      2'd2: base = `COB_TX3;
      2'd3: base = `COB_TX4;
    endcase
    return base + {4'h0, node};
  endfunction

  // Entry order per object: value, state, value, state
  function automatic logic [31:0] map_entry(input logic [1:0] pdo, input logic [1:0] ent);
    logic [7:0] sub;
    sub = {5'h00, pdo, ent[1]} + 8'h01;
    return ent[0] ? {`OBJ_STATE, sub, `SIZE_STATE} : {`OBJ_VALUE, sub, `SIZE_VALUE};
  endfunction

  function automatic logic delta_hit(input logic [15:0] pv, input logic [15:0] last,
                                     input logic [15:0] delta);
    logic signed [16:0] d;
    d = 17'($signed(pv)) - 17'($signed(last));
    if (d < 0) d = -d;
    return (delta != 16'h0000) && (d >= $signed({1'b0, delta}));
  endfunction

  assign idx = paddr[4:2];
  assign pready = ce & fresh_reg;
  assign wr_en = psel & penable & pwrite & pready;

  // Conversion request; disabled channels drop their samples
  assign cu.start = ce & sample_valid & en_reg[sample_chan];
  assign cu.current_mode = mode_reg[sample_chan];
  assign cu.chan = sample_chan;
  assign cu.raw = raw_field_value;
  assign cu.cal_gain = mode_reg[sample_chan] ? igain_reg[sample_chan] : vgain_reg[sample_chan];
  assign cu.cal_offset = mode_reg[sample_chan] ? ioff_reg[sample_chan] : voff_reg[sample_chan];
  assign cu.scale = sfact_reg[sample_chan];
  assign cu.soffset = soff_reg[sample_chan];

  channel_calc calc (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .cu(cu)
  );

  // Configuration registers
  always_comb begin
    node_next = node_reg;
    en_next = en_reg;
    mode_next = mode_reg;
    mask_next = mask_reg;
    delta_next = delta_reg;
    vgain_next = vgain_reg;
    voff_next = voff_reg;
    igain_next = igain_reg;
    ioff_next = ioff_reg;
    sfact_next = sfact_reg;
    soff_next = soff_reg;
    if (wr_en) begin
      if (paddr == `OFS_CTRL) node_next = pwdata[6:0];
      if (paddr == `OFS_CHAN_EN) en_next = pwdata[7:0];
      if (paddr == `OFS_MODE) mode_next = pwdata[7:0];
      if (paddr == `OFS_IRQ_MASK) mask_next = pwdata[1:0];
      if (in_arr(paddr, `OFS_DELTA)) delta_next[idx] = pwdata[15:0];
      if (in_arr(paddr, `OFS_VGAIN)) vgain_next[idx] = pwdata;
      if (in_arr(paddr, `OFS_VOFF)) voff_next[idx] = pwdata;
      if (in_arr(paddr, `OFS_IGAIN)) igain_next[idx] = pwdata;
      if (in_arr(paddr, `OFS_IOFF)) ioff_next[idx] = pwdata;
      if (in_arr(paddr, `OFS_SFACT)) sfact_next[idx] = pwdata;
      if (in_arr(paddr, `OFS_SOFF)) soff_next[idx] = pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_reg <= 7'h00;
      en_reg <= 8'h00;
      mode_reg <= 8'h00;
      mask_reg <= 2'b00;
      for (int i = 0; i < 8; i++) begin
        delta_reg[i] <= 16'h0000;
        vgain_reg[i] <= `RST_GAIN;
        voff_reg[i] <= `RST_ZERO;
        igain_reg[i] <= `RST_GAIN;
        ioff_reg[i] <= `RST_ZERO;
        sfact_reg[i] <= `RST_GAIN;
        soff_reg[i] <= `RST_ZERO;
      end
    end else if (ce) begin
      node_reg <= node_next;
      en_reg <= en_next;
      mode_reg <= mode_next;
      mask_reg <= mask_next;
      delta_reg <= delta_next;
      vgain_reg <= vgain_next;
      voff_reg <= voff_next;
      igain_reg <= igain_next;
      ioff_reg <= ioff_next;
      sfact_reg <= sfact_next;
      soff_reg <= soff_next;
    end
  end

  // Values, triggers, transmit and bus read side
  always_comb begin
    pv_next = pv_reg;
    cst_next = cst_reg;
    last_next = last_reg;
    set_pend = tx_request;
    clr_pend = 4'h0;
    irq_set = 2'b00;
    tx_state_next = tx_state_reg;
    tx_pdo_next = tx_pdo_reg;
    tx_cob_next = tx_cob_reg;
    tx_data_next = tx_data_reg;
    if (cu.done) begin
      pv_next[cu.done_chan] = cu.pv;
      cst_next[cu.done_chan] = cu.state;
      if (delta_hit(cu.pv, last_reg[cu.done_chan], delta_reg[cu.done_chan])) begin
        set_pend[cu.done_chan[2:1]] = 1'b1;
      end
      if (cu.state != `ST_OK) irq_set[`IRQ_RANGE] = 1'b1;
    end
    if (wr_en && paddr == `OFS_CTRL && pwdata[`CTRL_SEND_ALL]) set_pend = 4'hF;
    unique case (tx_state_reg)
      TX_IDLE: begin
        if (pending_reg != 4'h0) begin
          tx_pdo_next = low_pdo(pending_reg);
          tx_cob_next = cob_id(tx_pdo_next, node_reg);
          tx_data_next = {cst_reg[{tx_pdo_next, 1'b1}], pv_reg[{tx_pdo_next, 1'b1}],
                          cst_reg[{tx_pdo_next, 1'b0}], pv_reg[{tx_pdo_next, 1'b0}]};
          tx_state_next = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tx_ready) begin
          clr_pend[tx_pdo_reg] = 1'b1;
          // Baseline is what went out, not the latest sample
          last_next[{tx_pdo_reg, 1'b0}] = tx_data_reg[15:0];
          last_next[{tx_pdo_reg, 1'b1}] = tx_data_reg[39:24];
          irq_set[`IRQ_TX] = 1'b1;
          tx_state_next = TX_IDLE;
        end
      end
      default: tx_state_next = TX_IDLE;
    endcase
    // A new trigger wins over the clear of the object just sent
    pending_next = (pending_reg & ~clr_pend) | set_pend;
    irq_clr = (wr_en && paddr == `OFS_IRQ_STATUS) ? pwdata[1:0] : 2'b00;
    status_next = (status_reg & ~irq_clr) | irq_set;
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (in_arr(paddr, `OFS_DELTA)) rd_data = {16'h0000, delta_reg[idx]};
    else if (in_arr(paddr, `OFS_PV)) rd_data = {8'h00, cst_reg[idx], pv_reg[idx]};
    else if (in_arr(paddr, `OFS_VGAIN)) rd_data = vgain_reg[idx];
    else if (in_arr(paddr, `OFS_VOFF)) rd_data = voff_reg[idx];
    else if (in_arr(paddr, `OFS_IGAIN)) rd_data = igain_reg[idx];
    else if (in_arr(paddr, `OFS_IOFF)) rd_data = ioff_reg[idx];
    else if (in_arr(paddr, `OFS_SFACT)) rd_data = sfact_reg[idx];
    else if (in_arr(paddr, `OFS_SOFF)) rd_data = soff_reg[idx];
    else if ({paddr[11:6], 6'h00} == `OFS_MAP) rd_data = map_entry(paddr[5:4], paddr[3:2]);
    else if (paddr == `OFS_CTRL) rd_data = {25'h000_0000, node_reg};
    else if (paddr == `OFS_CHAN_EN) rd_data = {24'h00_0000, en_reg};
    else if (paddr == `OFS_MODE) rd_data = {24'h00_0000, mode_reg};
    else if (paddr == `OFS_IRQ_STATUS) rd_data = {30'h0000_0000, status_reg};
    else if (paddr == `OFS_IRQ_MASK) rd_data = {30'h0000_0000, mask_reg};
    else rd_err = 1'b1;
    // Data is captured in the setup cycle so the access needs no wait state
    prdata_next = (psel && !fresh_reg) ? rd_data : prdata_reg;
    err_next = (psel && !fresh_reg) ? rd_err : err_reg;
    fresh_next = psel & ~(penable & pready);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        pv_reg[i] <= 16'h0000;
        cst_reg[i] <= `ST_OK;
        last_reg[i] <= 16'h0000;
      end
      pending_reg <= 4'h0;
      status_reg <= 2'b00;
      tx_state_reg <= TX_IDLE;
      tx_pdo_reg <= 2'd0;
      tx_cob_reg <= 11'h000;
      tx_data_reg <= 48'h0000_0000_0000;
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
      fresh_reg <= 1'b0;
    end else if (ce) begin
      pv_reg <= pv_next;
      cst_reg <= cst_next;
      last_reg <= last_next;
      pending_reg <= pending_next;
      status_reg <= status_next;
      tx_state_reg <= tx_state_next;
      tx_pdo_reg <= tx_pdo_next;
      tx_cob_reg <= tx_cob_next;
      tx_data_reg <= tx_data_next;
      prdata_reg <= prdata_next;
      err_reg <= err_next;
      fresh_reg <= fresh_next;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = pready & err_reg;
  assign tx_valid = (tx_state_reg == TX_SEND);
  assign tx_cob_id = tx_cob_reg;
  assign tx_len = `TX_LEN;
  assign tx_data = tx_data_reg;
  assign irq = |(status_reg & mask_reg);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_cob_node: assert property (ce && tx_state_reg == TX_IDLE && pending_reg != 4'h0 |=>
    tx_cob_id - 11'($past(node_reg)) == 11'({7'h00, {2'b00, tx_pdo_reg} + 4'h1} << 8) + 11'h080)
    else $error("object identifier wrong");
  chk_pair_slot: assert property (ce && !tx_valid && pending_reg != 4'h0 && !cu.done |=>
    tx_data[15:0] == pv_reg[{tx_pdo_reg, 1'b0}] && tx_data[39:24] == pv_reg[{tx_pdo_reg, 1'b1}])
    else $error("channel pair misplaced");
  chk_state_slot: assert property (ce && !tx_valid && pending_reg != 4'h0 && !cu.done |=>
    tx_data[23:16] == cst_reg[{tx_pdo_reg, 1'b0}] && tx_data[47:40] == cst_reg[{tx_pdo_reg, 1'b1}])
    else $error("state byte misplaced");
  chk_map_size: assert property (ce && psel && !fresh_reg && {paddr[11:6], 6'h00} == `OFS_MAP |=>
    prdata[7:0] == ($past(paddr[2]) ? `SIZE_STATE : `SIZE_VALUE))
    else $error("mapping entry size wrong");
  chk_delta_off: assert property (ce && cu.done && delta_reg[cu.done_chan] == 16'h0000 &&
    tx_request == 4'h0 && !wr_en && pending_reg == 4'h0 |=> pending_reg == 4'h0)
    else $error("zero delta triggered a send");
  // Rising change of at least delta must schedule the carrying object
  chk_delta_fire: assert property (ce && cu.done && delta_reg[cu.done_chan] != 16'h0000 &&
    17'($signed(cu.pv)) - 17'($signed(last_reg[cu.done_chan])) >= 17'($signed({1'b0, delta_reg[cu.done_chan]}))
    |=> pending_reg[$past(cu.done_chan[2:1])])
    else $error("delta change not scheduled");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_cob_id))
    else $error("object dropped before ready");
  chk_irq_tx: assert property (ce && tx_valid && tx_ready |=> status_reg[`IRQ_TX])
    else $error("send interrupt missing");
endmodule

// >>> bench/can_master_model.sv
// Purpose: Far-side model that accepts transmit objects from the packer
// Assumes: One clock, objects handed over by valid/ready
// Notes: Ready is held back stall+1 cycles per object
`timescale 1ns/1ps
module can_master_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Object stream
  input wire logic tx_valid,
  input wire logic [10:0] tx_cob_id,
  input wire logic [3:0] tx_len,
  input wire logic [47:0] tx_data,
  output logic tx_ready,
  // Bench control and log
  input wire logic [3:0] stall,
  output logic [10:0] last_cob,
  output logic [3:0] last_len,
  output logic [47:0] last_data,
  output logic [7:0] got_cnt
);
  logic [3:0] wait_cnt;

  // Ready drops after each accept, so every object is seen as a fresh offer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      wait_cnt <= 4'h0;
      got_cnt <= 8'h00;
      last_cob <= 11'h000;
      last_len <= 4'h0;
      last_data <= 48'h0000_0000_0000;
    end else if (tx_valid && tx_ready) begin
      last_cob <= tx_cob_id;
      last_len <= tx_len;
      last_data <= tx_data;
      got_cnt <= got_cnt + 8'h01;
      tx_ready <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (tx_valid) begin
      if (wait_cnt >= stall) begin
        tx_ready <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule

// >>> bench/tb.sv
// Purpose: Self-checking bench of the analog value packer
// Assumes: Zero-wait APB slave, far side modelled by can_master_model
// Notes: Expected values come from a fixed-point model kept here
`timescale 1ns/1ps
`include "analog_pdo_defines.svh"
module tb;
  typedef struct packed {logic [11:0] addr; logic [31:0] exp;} row_t;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, sample_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] sample_chan;
  logic [15:0] raw_field_value;
  logic [3:0] tx_request, tx_len, last_len, stall;
  logic tx_valid, tx_ready, irq;
  logic [10:0] tx_cob_id, last_cob;
  logic [47:0] tx_data, last_data;
  logic [7:0] got_cnt;
  int errors, checked;
  row_t rows[$];
  logic [23:0] epv[8];
  logic [31:0] g[8], o[8], sf[8], so[8];
  logic [7:0] mode_bits;

  analog_pdo_packer i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_chan(sample_chan), .raw_field_value(raw_field_value),
    .tx_request(tx_request), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_cob_id(tx_cob_id),
    .tx_len(tx_len), .tx_data(tx_data), .irq(irq));
  can_master_model i_can (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx_cob_id(tx_cob_id),
    .tx_len(tx_len), .tx_data(tx_data), .tx_ready(tx_ready), .stall(stall), .last_cob(last_cob),
    .last_len(last_len), .last_data(last_data), .got_cnt(got_cnt));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, wd, d, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0000_0000, d, e);
    check({e, d}, {1'b0, exp});
  endtask

  task automatic sample(input logic [2:0] ch, input logic [15:0] raw);
    @(posedge pclk);
    sample_valid <= 1'b1;
    sample_chan <= ch;
    raw_field_value <= raw;
    @(posedge pclk);
    sample_valid <= 1'b0;
    epv[ch] = exp_pv(raw, mode_bits[ch], g[ch], o[ch], sf[ch], so[ch]);
  endtask

  task automatic wait_obj(input int n);
    int k;
    k = 0;
    while (got_cnt < n && k < 300) begin
      @(posedge pclk);
      k++;
    end
    if (got_cnt < n) begin
      errors++;
      print_verdict();
    end
  endtask

  function automatic logic [23:0] exp_pv(input logic [15:0] raw, input logic cur, input logic [31:0] gn,
                                         input logic [31:0] of, input logic [31:0] sc, input logic [31:0] sof);
    longint u, c, f;
    u = (longint'($signed(raw)) * (cur ? longint'(`K_CURR) : longint'(`K_VOLT))) >>> 16;
    c = ((u * longint'($signed(gn))) >>> 16) + longint'($signed(of));
    f = (((c * longint'($signed(sc))) >>> 16) + longint'($signed(sof))) >>> 16;
    if (f > 32767) return {`ST_OVER, 16'h7FFF};
    if (f < -32768) return {`ST_UNDER, 16'h8000};
    return {`ST_OK, f[15:0]};
  endfunction

  // Object n carries channels 2n and 2n+1, low byte first
  function automatic logic [47:0] obj_data(input int n);
    return {epv[2*n+1][23:16], epv[2*n+1][15:0], epv[2*n][23:16], epv[2*n][15:0]};
  endfunction

  function automatic logic [10:0] cob_of(input int n);
    logic [10:0] base[4] = '{`COB_TX1, `COB_TX2, `COB_TX3, `COB_TX4};
    return base[n] + 11'h005;
  endfunction

  task automatic obj_chk(input int n);
    check(last_cob, cob_of(n));
    check(last_data, obj_data(n));
    check(last_len, `TX_LEN);
  endtask

  initial begin
    {ce, presetn, psel, penable, pwrite, sample_valid} = 6'b100000;
    {paddr, pwdata, sample_chan, raw_field_value, tx_request, stall} = '0;
    mode_bits = 8'h00;
    for (int i = 0; i < 8; i++) begin
      {g[i], o[i], sf[i], so[i], epv[i]} = {`RST_GAIN, `RST_ZERO, `RST_GAIN, `RST_ZERO, 24'h00_0000};
    end
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then the read-only mapping table
    rows = '{'{`OFS_CTRL, 0}, '{`OFS_CHAN_EN, 0}, '{`OFS_MODE, 0}, '{`OFS_IRQ_STATUS, 0}, '{`OFS_IRQ_MASK, 0},
             '{`OFS_DELTA + 12'h01C, 0}, '{`OFS_PV + 12'h004, 0}, '{`OFS_VGAIN, `RST_GAIN},
             '{`OFS_VOFF + 12'h004, 0}, '{`OFS_IGAIN + 12'h01C, `RST_GAIN}, '{`OFS_SFACT + 12'h008, `RST_GAIN}};
    for (int n = 0; n < 4; n++) begin
      for (int e = 0; e < 4; e++) begin
        rows.push_back('{`OFS_MAP + 12'(16 * n + 4 * e), {(e[0] ? `OBJ_STATE : `OBJ_VALUE),
                         8'(2 * n + 1 + e / 2), (e[0] ? `SIZE_STATE : `SIZE_VALUE)}});
      end
    end
    foreach (rows[i]) rd_chk(rows[i].addr, rows[i].exp);
    $display("Test reset_and_map done");
    // Unmapped place answers with an error and reads zero
    begin
      logic [31:0] d;
      logic e;
      apb(1'b0, 12'h200, 32'h0000_0000, d, e);
      check({e, d}, {1'b1, 32'h0000_0000});
      apb(1'b1, 12'h204, 32'h0000_FFFF, d, e);
      check(e, 1'b1);
    end
    $display("Test unmapped done");
    // Configuration in the prescribed order, channels enabled last
    mode_bits = 8'h04;
    {g[1], o[1], sf[1], so[1]} = {32'h0002_0000, 32'h0001_0000, 32'h0003_0000, 32'h0005_0000};
    {sf[2], sf[3], sf[4]} = {32'h03E8_0000, 32'h07D0_0000, 32'h07D0_0000};
    wr(`OFS_MODE, {24'h00_0000, mode_bits});
    wr(`OFS_CTRL, 32'h0000_0005);
    for (int c = 0; c < 8; c++) begin
      wr((mode_bits[c] ? `OFS_IGAIN : `OFS_VGAIN) + 12'(4 * c), g[c]);
      wr((mode_bits[c] ? `OFS_IOFF : `OFS_VOFF) + 12'(4 * c), o[c]);
      wr(`OFS_SFACT + 12'(4 * c), sf[c]);
      wr(`OFS_SOFF + 12'(4 * c), so[c]);
    end
    wr(`OFS_DELTA, 32'h0000_0010);
    wr(`OFS_CHAN_EN, 32'h0000_003F);
    // Zero delta never triggers; disabled channel is dropped
    for (int c = 1; c < 5; c++) sample(3'(c), c == 4 ? 16'h8000 : 16'h7FFF);
    sample(3'h6, 16'h7FFF);
    epv[6] = 24'h00_0000;
    repeat (10) @(posedge pclk);
    check(got_cnt, 8'h00);
    for (int c = 1; c < 7; c++) rd_chk(`OFS_PV + 12'(4 * c), {8'h00, epv[c]});
    $display("Test conversion done");
    // Change of at least delta sends the first object, repeat value does not
    sample(3'h0, 16'h7FFF);
    wait_obj(1);
    obj_chk(0);
    sample(3'h0, 16'h7FFF);
    repeat (10) @(posedge pclk);
    check(got_cnt, 8'h01);
    $display("Test delta_trigger done");
    // Send all four with a slow far side, then one on request
    stall <= 4'h4;
    wr(`OFS_CTRL, 32'h0000_0105);
    for (int n = 0; n < 4; n++) begin
      wait_obj(2 + n);
      obj_chk(n);
    end
    stall <= 4'h0;
    @(posedge pclk);
    tx_request <= 4'h8;
    @(posedge pclk);
    tx_request <= 4'h0;
    wait_obj(6);
    obj_chk(3);
    $display("Test send_all done");
    // Sticky status, mask and write-one clear
    rd_chk(`OFS_IRQ_STATUS, 32'h0000_0003);
    check(irq, 1'b0);
    wr(`OFS_IRQ_MASK, 32'h0000_0001);
    @(posedge pclk);
    check(irq, 1'b1);
    wr(`OFS_IRQ_STATUS, 32'h0000_0001);
    @(posedge pclk);
    check(irq, 1'b0);
    rd_chk(`OFS_IRQ_STATUS, 32'h0000_0002);
    wr(`OFS_IRQ_MASK, 32'h0000_0003);
    @(posedge pclk);
    check(irq, 1'b1);
    wr(`OFS_IRQ_STATUS, 32'h0000_0002);
    @(posedge pclk);
    check(irq, 1'b0);
    $display("Test interrupt done");
    // Sample and send request are both lost while ce is low
    ce <= 1'b0;
    @(posedge pclk);
    sample_valid <= 1'b1;
    raw_field_value <= 16'h0000;
    tx_request <= 4'h1;
    @(posedge pclk);
    sample_valid <= 1'b0;
    tx_request <= 4'h0;
    ce <= 1'b1;
    repeat (10) @(posedge pclk);
    check(got_cnt, 8'h06);
    rd_chk(`OFS_PV, {8'h00, epv[0]});
    $display("Test clock_enable done");
    print_verdict();
  end
endmodule
